// ### src/cep_counter.sv
`timescale 1ns/100ps
`include "cep_defines.svh"
// Functional notes
// [R1] count selected source edges after arm
// [R2] software count read never disturbs counting
// [R3] pause active ignores source edges
// [R4] pause from gate, polarity selectable
// [R5] sample clock edge pushes count to fifo
// [R6] samples cumulative, sampling never clears count
// [R7] counting starts at arm, not sample edge
// [R8] sample clock edge polarity selectable
// [R9] direction up, down or by input
// [R10] pulse width counts while gate active
// [R11] armed in active gate waits next pulse
// [R12] single width stores once then stops
// [R13] implicit width stores every trailing edge
// [R14] sampled width stores last completed pulse
// [R15] no pulse between samples raises overrun
// [R16] pulse mode measures high and low times
// [R17] implicit pulse stores on every gate edge
// [R18] first edge select picks first phase
// [R19] sampled pulse stores high and low ticks
// [R20] fifo streamed out to host transfer engine
// [R21] count register 32 bits wide
// [R22] sample clock supplied from outside
// [R23] count wraps modulo register width
// [R24] inputs synchronised before edge detection
module cep_counter
   import cep_pkg::*;
#(
   parameter int WIDTH = 32, // [R21]
   parameter int DEPTH = 16
) (
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        source_i,
   input  wire logic        gate_i,
   input  wire logic        sample_clk_i,
   input  wire logic        dir_sel_i,
   output logic [WIDTH-1:0] stream_data_o,
   output logic             stream_valid_o,
   input  wire logic        stream_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic src_lvl, src_rise, src_fall;
   logic gate_lvl, gate_rise, gate_fall;
   logic smp_lvl, smp_rise, smp_fall;
   logic dir_lvl;

   // [R24]
   cep_sync_edge u_src (.clock_i(clock_i), .reset_i(reset_i), .async_i(source_i),
                        .level_o(src_lvl), .rise_o(src_rise), .fall_o(src_fall));
   cep_sync_edge u_gate (.clock_i(clock_i), .reset_i(reset_i), .async_i(gate_i),
                         .level_o(gate_lvl), .rise_o(gate_rise), .fall_o(gate_fall));
   cep_sync_edge u_smp (.clock_i(clock_i), .reset_i(reset_i), .async_i(sample_clk_i),
                        .level_o(smp_lvl), .rise_o(smp_rise), .fall_o(smp_fall));
   cep_sync_edge u_dir (.clock_i(clock_i), .reset_i(reset_i), .async_i(dir_sel_i),
                        .level_o(dir_lvl), .rise_o(), .fall_o());

   // configuration
   logic [31:0] mode;
   cep_func_t   func;
   cep_dir_t    dir_cfg;
   logic        src_fall_sel, smp_fall_sel, pause_en, pause_low, gate_low, first_low;

   assign func         = cep_func_t'(mode[`CEP_MODE_FUNC_HI:`CEP_MODE_FUNC_LO]);
   assign dir_cfg      = cep_dir_t'(mode[`CEP_MODE_DIR_HI:`CEP_MODE_DIR_LO]);
   assign src_fall_sel = mode[`CEP_MODE_SRC_FALL];
   assign smp_fall_sel = mode[`CEP_MODE_SMP_FALL];
   assign pause_en     = mode[`CEP_MODE_PAUSE_EN];
   assign pause_low    = mode[`CEP_MODE_PAUSE_LOW];
   assign gate_low     = mode[`CEP_MODE_GATE_LOW];
   assign first_low    = mode[`CEP_MODE_FIRST_LOW];

   // event qualifiers
   logic src_edge, smp_edge, paused, act_lvl, act_start, act_end;
   logic first_start, edge_mode, pulse_mode, sampled_mode;
   assign src_edge   = src_fall_sel ? src_fall : src_rise;            // [R1]
   assign smp_edge   = smp_fall_sel ? smp_fall : smp_rise;            // [R8] [R22]
   assign paused     = pause_en & (pause_low ? ~gate_lvl : gate_lvl); // [R3] [R4]
   assign act_lvl    = gate_low ? ~gate_lvl : gate_lvl;
   assign act_start  = gate_low ? gate_fall : gate_rise;
   assign act_end    = gate_low ? gate_rise : gate_fall;
   assign first_start = first_low ? gate_fall : gate_rise;            // [R18]
   assign edge_mode  = (func == CEP_FN_EDGE_DEMAND) | (func == CEP_FN_EDGE_SAMPLED);
   assign pulse_mode = (func == CEP_FN_PULSE_IMPLICIT) | (func == CEP_FN_PULSE_SAMPLED) |
                       (func == CEP_FN_PULSE_SINGLE);
   assign sampled_mode = (func == CEP_FN_PW_SAMPLED) | (func == CEP_FN_PULSE_SAMPLED);

   // bus strobes
   logic bus_req, wr_ctrl, wr_mode, rd_fifo, wr_stat;
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctrl = bus_req & wb_we_i & (wb_adr_i == `CEP_ADR_CTRL) & wb_sel_i[0];
   assign wr_mode = bus_req & wb_we_i & (wb_adr_i == `CEP_ADR_MODE);
   assign wr_stat = bus_req & wb_we_i & (wb_adr_i == `CEP_ADR_STATUS) & wb_sel_i[0];
   assign rd_fifo = bus_req & ~wb_we_i & (wb_adr_i == `CEP_ADR_FIFO);

   logic arm_cmd, disarm_cmd;
   assign arm_cmd    = wr_ctrl & wb_dat_i[`CEP_CTRL_ARM];
   assign disarm_cmd = wr_ctrl & wb_dat_i[`CEP_CTRL_DISARM];

   // measurement state
   typedef enum logic [1:0] {CEP_IDLE, CEP_WAIT, CEP_RUN, CEP_DONE} cep_state_t;
   cep_state_t state;
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] hi_ticks, lo_ticks;
   logic             have_pulse, phase_hi, overrun;

   logic push_a, push_b;
   logic [WIDTH-1:0] push_a_data, push_b_data;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         mode <= `CEP_MODE_RESET;
      end else if (wr_mode) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               mode[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
         end
      end
   end

   // arm / run sequencing
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state <= CEP_IDLE;
      end else if (disarm_cmd) begin
         state <= CEP_IDLE;
      end else if (arm_cmd) begin
         state <= edge_mode ? CEP_RUN : CEP_WAIT; // [R7] [R11]
      end else begin
         unique case (state)
            CEP_IDLE: state <= CEP_IDLE;
            CEP_WAIT: begin
               if (pulse_mode ? first_start : act_start) begin
                  state <= CEP_RUN; // [R11] [R18]
               end
            end
            CEP_RUN: begin
               if (func == CEP_FN_PW_SINGLE && act_end) begin
                  state <= CEP_DONE; // [R12]
               end else if (func == CEP_FN_PULSE_SINGLE && phase_hi == first_low
                            && (gate_rise | gate_fall)) begin
                  state <= CEP_DONE;
               end
            end
            CEP_DONE: state <= CEP_DONE; // [R12]
         endcase
      end
   end

   // running count
   logic [WIDTH-1:0] step_val;
   logic             down;
   always_comb begin
      unique case (dir_cfg)
         CEP_DIR_DOWN: down = 1'b1;
         CEP_DIR_EXT:  down = ~dir_lvl;
         default:      down = 1'b0;
      endcase
   end
   // [R9] [R23]
   assign step_val = down ? count - WIDTH'(1) : count + WIDTH'(1);

   logic gate_edge_run;
   assign gate_edge_run = (state == CEP_RUN) & (pulse_mode ? (gate_rise | gate_fall) : act_end);

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         count <= '0;
      end else if (arm_cmd) begin
         count <= '0;
      end else if (state == CEP_RUN) begin
         if (edge_mode) begin
            if (src_edge && !paused) begin
               count <= step_val; // [R1] [R3] [R6]
            end
         end else if (gate_edge_run) begin
            count <= '0;
         end else if (src_edge && (pulse_mode || act_lvl)) begin
            count <= count + WIDTH'(1); // [R10] [R16]
         end
      end
   end

   // phase tracking for pulse mode: phase_hi means the high time is running
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         phase_hi <= 1'b0;
      end else if (state == CEP_WAIT && first_start) begin
         phase_hi <= ~first_low;
      end else if (gate_edge_run) begin
         phase_hi <= ~phase_hi;
      end
   end

   // completed pulse record for sampled modes
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         hi_ticks   <= '0;
         lo_ticks   <= '0;
         have_pulse <= 1'b0;
      end else if (arm_cmd) begin
         have_pulse <= 1'b0;
      end else begin
         if (gate_edge_run && pulse_mode) begin
            if (phase_hi) begin
               hi_ticks <= count;
            end else begin
               lo_ticks <= count;
            end
         end else if (gate_edge_run) begin
            hi_ticks <= count; // [R14]
         end
         // a pulse completes when its trailing phase closes; set wins over the sample clear
         if (gate_edge_run && (!pulse_mode || phase_hi == first_low)) begin
            have_pulse <= 1'b1;
         end else if (smp_edge && state == CEP_RUN && sampled_mode) begin
            have_pulse <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         overrun <= 1'b0;
      end else if (smp_edge && state == CEP_RUN && sampled_mode && !have_pulse) begin
         overrun <= 1'b1; // [R15]
      end else if (arm_cmd || (wr_stat && wb_dat_i[`CEP_STAT_OVERRUN])) begin
         overrun <= 1'b0;
      end
   end

   // fifo push selection
   always_comb begin
      push_a      = 1'b0;
      push_b      = 1'b0;
      push_a_data = count;
      push_b_data = '0;
      if (state == CEP_RUN) begin
         unique case (func)
            CEP_FN_EDGE_SAMPLED: push_a = smp_edge; // [R5] [R6]
            CEP_FN_PW_SINGLE, CEP_FN_PW_IMPLICIT: push_a = act_end; // [R12] [R13]
            CEP_FN_PULSE_IMPLICIT, CEP_FN_PULSE_SINGLE: push_a = gate_edge_run; // [R17]
            CEP_FN_PW_SAMPLED: begin
               push_a      = smp_edge & have_pulse; // [R14]
               push_a_data = hi_ticks;
            end
            CEP_FN_PULSE_SAMPLED: begin
               push_a      = smp_edge & have_pulse; // [R19]
               push_b      = smp_edge & have_pulse;
               push_a_data = hi_ticks;
               push_b_data = lo_ticks;
            end
            default: push_a = 1'b0;
         endcase
      end
   end

   // counter fifo, drained by the stream port or by bus reads
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr;
   logic [AW:0]      level;
   logic             fifo_ovf, pop;
   logic [1:0]       n_push;
   logic [AW:0]      room;
   assign pop    = (level != '0) & (stream_ready_i | rd_fifo); // [R20]
   assign room   = (AW+1)'(DEPTH) - level + (AW+1)'(pop);
   assign n_push = (push_a && room != '0) ? ((push_b && room > (AW+1)'(1)) ? 2'd2 : 2'd1)
                                          : 2'd0;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else if (arm_cmd) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else begin
         if (n_push != 2'd0) begin
            mem[wr_ptr] <= push_a_data;
         end
         if (n_push == 2'd2) begin
            mem[AW'(wr_ptr + AW'(1))] <= push_b_data; // [R19]
         end
         wr_ptr <= AW'(wr_ptr + AW'(n_push));
         rd_ptr <= AW'(rd_ptr + AW'(pop));
         level  <= level + (AW+1)'(n_push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         fifo_ovf <= 1'b0;
      end else if ((push_a || push_b) && n_push != {1'b0, push_a} + {1'b0, push_b}) begin
         fifo_ovf <= 1'b1;
      end else if (arm_cmd || (wr_stat && wb_dat_i[`CEP_STAT_FIFO_OVF])) begin
         fifo_ovf <= 1'b0;
      end
   end

   assign stream_valid_o = (level != '0);
   assign stream_data_o  = mem[rd_ptr];

   // wishbone read and ack
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (wb_adr_i)
         `CEP_ADR_MODE:   next_rdata = mode;
         `CEP_ADR_STATUS: begin
            next_rdata[`CEP_STAT_ARMED]    = (state != CEP_IDLE);
            next_rdata[`CEP_STAT_DONE]     = (state == CEP_DONE);
            next_rdata[`CEP_STAT_OVERRUN]  = overrun;
            next_rdata[`CEP_STAT_FIFO_OVF] = fifo_ovf;
            next_rdata[`CEP_STAT_EMPTY]    = (level == '0);
         end
         `CEP_ADR_COUNT:  next_rdata = 32'(count); // [R2]
         `CEP_ADR_FIFO:   next_rdata = (level != '0) ? 32'(mem[rd_ptr]) : 32'h0000_0000;
         `CEP_ADR_LEVEL:  next_rdata = 32'(level);
         default:         next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
         end
      end
   end
endmodule : cep_counter

// ### src/cep_defines.svh
`ifndef CEP_DEFINES_SVH
`define CEP_DEFINES_SVH

// register byte offsets on the wishbone bus
`define CEP_ADR_CTRL     8'h00
`define CEP_ADR_MODE     8'h04
`define CEP_ADR_STATUS   8'h08
`define CEP_ADR_COUNT    8'h0C
`define CEP_ADR_FIFO     8'h10
`define CEP_ADR_LEVEL    8'h14

// ctrl fields
`define CEP_CTRL_ARM     0
`define CEP_CTRL_DISARM  1

// mode fields
`define CEP_MODE_FUNC_LO     0
`define CEP_MODE_FUNC_HI     2
`define CEP_MODE_SRC_FALL    4
`define CEP_MODE_SMP_FALL    5
`define CEP_MODE_PAUSE_EN    6
`define CEP_MODE_PAUSE_LOW   7
`define CEP_MODE_DIR_LO      8
`define CEP_MODE_DIR_HI      9
`define CEP_MODE_GATE_LOW    10
`define CEP_MODE_FIRST_LOW   11

// status fields
`define CEP_STAT_ARMED    0
`define CEP_STAT_DONE     1
`define CEP_STAT_OVERRUN  2
`define CEP_STAT_FIFO_OVF 3
`define CEP_STAT_EMPTY    4

`define CEP_MODE_RESET   32'h0000_0000
`define CEP_SYNC_STAGES  2

`endif

// ### src/cep_pkg.sv
package cep_pkg;
   typedef enum logic [2:0] {
      CEP_FN_EDGE_DEMAND,
      CEP_FN_EDGE_SAMPLED,
      CEP_FN_PW_SINGLE,
      CEP_FN_PW_IMPLICIT,
      CEP_FN_PW_SAMPLED,
      CEP_FN_PULSE_IMPLICIT,
      CEP_FN_PULSE_SAMPLED,
      CEP_FN_PULSE_SINGLE
   } cep_func_t;

   typedef enum logic [1:0] {
      CEP_DIR_UP,
      CEP_DIR_DOWN,
      CEP_DIR_EXT,
      CEP_DIR_UP2
   } cep_dir_t;
endpackage : cep_pkg

// ### src/cep_sync_edge.sv
`timescale 1ns/100ps
// two-flop synchroniser with edge detection on the settled copy
module cep_sync_edge (
   input  wire logic clock_i,
   input  wire logic reset_i,
   input  wire logic async_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta;
   logic settled;
   logic prev;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         meta    <= 1'b0;
         settled <= 1'b0;
         prev    <= 1'b0;
      end else begin
         meta    <= async_i;
         settled <= meta;
         prev    <= settled;
      end
   end

   assign level_o = settled;
   assign rise_o  = settled & ~prev;
   assign fall_o  = ~settled & prev;
endmodule : cep_sync_edge

// ### tb/cep_counter_assertions.sv
`timescale 1ns/100ps
`include "cep_defines.svh"
module cep_counter_chk #(
   parameter int WIDTH = 32
) (
   input wire logic             clock_i,
   input wire logic             reset_i,
   input wire logic [7:0]       wb_adr_i,
   input wire logic [31:0]      wb_dat_i,
   input wire logic [3:0]       wb_sel_i,
   input wire logic             wb_we_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o,
   input wire logic             source_i,
   input wire logic             gate_i,
   input wire logic             sample_clk_i,
   input wire logic             dir_sel_i,
   input wire logic [WIDTH-1:0] stream_data_o,
   input wire logic             stream_valid_o,
   input wire logic             stream_ready_i
);
   logic [7:0] gate_h;
   logic [7:0] smp_h;
   // recent pin history: a push needs a gate or sample edge shortly before
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         gate_h <= 8'h00;
         smp_h  <= 8'h00;
      end else begin
         gate_h <= {gate_h[6:0], gate_i};
         smp_h  <= {smp_h[6:0], sample_clk_i};
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_wait; !wb_cyc_i && stream_valid_o && !stream_ready_i; endsequence
   property p_ack_resp; s_take |=> wb_ack_o; endproperty
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i); endproperty
   property p_unmapped; s_take ##0 (!wb_we_i && wb_adr_i > 8'h14) |=> wb_dat_o == 32'h0;
   endproperty
   property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
   property p_stream_hold; s_wait |=> stream_valid_o && $stable(stream_data_o); endproperty
   property p_push_cause;
      $rose(stream_valid_o) |-> gate_h != {8{gate_h[0]}} || smp_h != {8{smp_h[0]}};
   endproperty
   property p_reset_quiet; $fell(reset_i) |-> !stream_valid_o && !wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp)
      else $error("no ack after request");
   a_ack_once: assert property (p_ack_once)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_dat_hold: assert property (p_dat_hold)
      else $error("read data moved without ack");
   a_stream_hold: assert property (p_stream_hold)
      else $error("stream head changed while stalled");
   a_push_cause: assert property (p_push_cause)
      else $error("push without gate or sample edge");
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active after reset");
endmodule : cep_counter_chk
bind cep_counter cep_counter_chk #(.WIDTH(WIDTH)) u_chk (
   .clock_i(clock_i), .reset_i(reset_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .source_i(source_i), .gate_i(gate_i),
   .sample_clk_i(sample_clk_i), .dir_sel_i(dir_sel_i), .stream_data_o(stream_data_o),
   .stream_valid_o(stream_valid_o), .stream_ready_i(stream_ready_i));

// ### tb/cep_sig_src.sv
`timescale 1ns/100ps
module cep_sig_src (
   input  wire logic clock_i,
   output logic      source_o,
   output logic      gate_o,
   output logic      sample_clk_o,
   output logic      dir_sel_o
);
   initial begin
      {source_o, gate_o, sample_clk_o, dir_sel_o} = 4'h0;
   end
   // pins change just after an edge and settle long enough to be seen
   task automatic set(input int pin, input logic v);
      @(posedge clock_i);
      case (pin)
         0: source_o <= v;
         1: gate_o <= v;
         2: sample_clk_o <= v;
         default: dir_sel_o <= v;
      endcase
      repeat (5) @(posedge clock_i);
   endtask : set
   task automatic src(input int n);
      repeat (n) begin
         set(0, 1'b1);
         set(0, 1'b0);
      end
   endtask : src
   task automatic gpulse(input int n);
      set(1, 1'b1);
      src(n);
      set(1, 1'b0);
   endtask : gpulse
endmodule : cep_sig_src

// ### tb/tb_cep_counter.sv
`timescale 1ns/100ps
`include "cep_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_cep_counter;
   logic        clock_i, reset_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [7:0]  wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, stream_data_o, rdat;
   logic [3:0]  wb_sel_i;
   logic        source_i, gate_i, sample_clk_i, dir_sel_i, stream_valid_o, stream_ready_i;
   int          n_mismatch = 0;
   int          checked = 0;
   cep_counter dut (.clock_i(clock_i), .reset_i(reset_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .source_i(source_i),
      .gate_i(gate_i), .sample_clk_i(sample_clk_i), .dir_sel_i(dir_sel_i),
      .stream_data_o(stream_data_o), .stream_valid_o(stream_valid_o),
      .stream_ready_i(stream_ready_i));
   cep_sig_src p (.clock_i(clock_i), .source_o(source_i), .gate_o(gate_i),
      .sample_clk_o(sample_clk_i), .dir_sel_o(dir_sel_i));
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   task automatic close_out();
      $display("checked %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge clock_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      i = 0;
      do begin
         @(posedge clock_i);
         i++;
         rdat = wb_dat_o;
      end while (wb_ack_o !== 1'b1 && i < 20);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      if (i >= 20) begin n_mismatch++; close_out(); end
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      `CHK(rdat, e)
   endtask : rd
   task automatic run(input logic [31:0] m);
      bus(`CEP_ADR_MODE, 1'b1, m);
      bus(`CEP_ADR_CTRL, 1'b1, 32'h1);
   endtask : run
   task automatic pop(input logic [31:0] e);
      int i;
      for (i = 0; i < 40 && stream_valid_o !== 1'b1; i++) @(posedge clock_i);
      if (stream_valid_o !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
      `CHK(stream_data_o, e)
      @(posedge clock_i) stream_ready_i <= 1'b1;
      @(posedge clock_i) stream_ready_i <= 1'b0;
      @(posedge clock_i);
   endtask : pop
   initial begin
      repeat (50000) @(posedge clock_i);
      n_mismatch++;
      close_out();
   end
   initial begin
      {reset_i, wb_cyc_i, wb_stb_i, wb_we_i, stream_ready_i} = 5'h10;
      {wb_adr_i, wb_dat_i, wb_sel_i} = {8'h00, 32'h0, 4'hF};
      repeat (4) @(posedge clock_i);
      reset_i <= 1'b0;
      rd(8'h20, 32'h0);
      rd(`CEP_ADR_MODE, `CEP_MODE_RESET);
      wb_sel_i <= 4'h2;
      bus(`CEP_ADR_MODE, 1'b1, 32'hFFFF_FFFF);
      wb_sel_i <= 4'hF;
      rd(`CEP_ADR_MODE, 32'h0000_FF00);
      run(32'h0);
      p.src(5);
      rd(`CEP_ADR_COUNT, 32'h5);
      rd(`CEP_ADR_COUNT, 32'h5);
      run(32'h100);
      p.src(3);
      rd(`CEP_ADR_COUNT, 32'hFFFF_FFFD);
      run(32'h200);
      p.set(3, 1'b1);
      p.src(2);
      p.set(3, 1'b0);
      p.src(1);
      rd(`CEP_ADR_COUNT, 32'h1);
      run(32'h300);
      p.src(1);
      rd(`CEP_ADR_COUNT, 32'h1);
      for (int k = 0; k < 2; k++) begin
         run(32'h40 | (k << 7));
         p.set(1, ~k[0]);
         p.src(3);
         p.set(1, k[0]);
         p.src(2);
         rd(`CEP_ADR_COUNT, 32'h2);
      end
      $display("test edge counting done");
      run(32'h21);
      p.src(2);
      p.set(2, 1'b1);
      rd(`CEP_ADR_LEVEL, 32'h0);
      p.set(2, 1'b0);
      p.src(3);
      p.set(2, 1'b1);
      p.set(2, 1'b0);
      pop(32'h2);
      rd(`CEP_ADR_FIFO, 32'h5);
      $display("test buffered edge done");
      p.set(1, 1'b1);
      run(32'h2);
      p.src(2);
      p.set(1, 1'b0);
      p.gpulse(4);
      p.gpulse(2);
      rd(`CEP_ADR_LEVEL, 32'h1);
      pop(32'h4);
      run(32'h3);
      p.gpulse(3);
      p.gpulse(2);
      pop(32'h3);
      pop(32'h2);
      run(32'h4);
      p.gpulse(3);
      p.set(2, 1'b1);
      p.set(2, 1'b0);
      pop(32'h3);
      p.set(2, 1'b1);
      bus(`CEP_ADR_STATUS, 1'b0, 32'h0);
      `CHK(rdat[2], 1'b1)
      bus(`CEP_ADR_STATUS, 1'b1, 32'h4);
      rd(`CEP_ADR_LEVEL, 32'h0);
      rd(`CEP_ADR_STATUS, 32'h11);
      $display("test pulse width done");
      run(32'h5);
      p.src(2);
      p.gpulse(2);
      p.src(3);
      p.set(1, 1'b1);
      pop(32'h2);
      pop(32'h3);
      p.set(1, 1'b0);
      run(32'h6);
      p.gpulse(2);
      p.src(1);
      p.set(1, 1'b1);
      p.set(2, 1'b0);
      p.set(2, 1'b1);
      pop(32'h2);
      pop(32'h1);
      $display("test pulse done");
      run(32'h817);
      p.set(1, 1'b0);
      p.src(2);
      p.set(1, 1'b1);
      p.src(3);
      p.set(1, 1'b0);
      p.gpulse(1);
      rd(`CEP_ADR_STATUS, 32'h3);
      rd(`CEP_ADR_LEVEL, 32'h2);
      pop(32'h2);
      pop(32'h3);
      bus(`CEP_ADR_CTRL, 1'b1, 32'h2);
      rd(`CEP_ADR_STATUS, 32'h10);
      $display("test pulse single done");
      run(32'h403);
      p.src(1);
      p.set(1, 1'b1);
      p.set(1, 1'b0);
      p.src(2);
      p.set(1, 1'b1);
      pop(32'h2);
      run(32'h1);
      for (int k = 0; k < 17; k++) begin
         p.set(2, 1'b0);
         p.set(2, 1'b1);
      end
      rd(`CEP_ADR_LEVEL, 32'h10);
      rd(`CEP_ADR_STATUS, 32'h9);
      $display("test low gate and overflow done");
      close_out();
   end
endmodule : tb_cep_counter
